// ---- core/xdip_pkg.sv ----
package xdip_pkg;
  // Decode classes
  typedef enum logic [1:0] {
    CLS_SHORT = 2'b00,
    CLS_LONG = 2'b01,
    CLS_VECTOR = 2'b10
  } xdip_class_e;
  // Issue targets
  typedef enum logic [2:0] {
    UNIT_INTX = 3'b000,
    UNIT_INTY = 3'b001,
    UNIT_FPU = 3'b010,
    UNIT_BRANCH = 3'b011,
    UNIT_LOAD = 3'b100,
    UNIT_STORE = 3'b101
  } xdip_unit_e;
  // Operation kinds presented by the predecoder
  typedef enum logic [2:0] {
    OP_ALU = 3'b000,
    OP_CARRY = 3'b001,
    OP_SHIFT_IMM = 3'b010,
    OP_FP = 3'b011,
    OP_COND_JUMP = 3'b100,
    OP_LOAD = 3'b101,
    OP_STORE = 3'b110,
    OP_MICRO = 3'b111
  } xdip_op_e;
  localparam logic [3:0] SHORT_MAX_LEN = 4'h7;
  localparam logic [2:0] MISPRED_MIN = 3'h1;
  localparam logic [2:0] MISPRED_MAX = 3'h4;
  localparam logic [1:0] MISALIGN_EXTRA = 2'h1;
  localparam logic [1:0] PREFIX_FREE = 2'h1;
endpackage : xdip_pkg

// ---- core/xdip_slot_if.sv ----
`timescale 1ns/1ps
interface xdip_slot_if;
  logic valid;
  logic [3:0] length;
  logic [1:0] prefixCount;
  xdip_pkg::xdip_op_e op;
  logic misaligned;
  xdip_pkg::xdip_class_e decClass;
  xdip_pkg::xdip_unit_e unit;
  logic needsPrefixDelay;
  logic accessDelay;
  modport decoder (input length, prefixCount, op, misaligned, valid,
    output decClass, unit, needsPrefixDelay, accessDelay);
  modport user (output length, prefixCount, op, misaligned, valid,
    input decClass, unit, needsPrefixDelay, accessDelay);
endinterface : xdip_slot_if

// ---- core/xdip_classify.sv ----
`timescale 1ns/1ps
module xdip_classify (
  xdip_slot_if.decoder slot
);
  always_comb begin
    // Over seven bytes goes long or vector only
    if (slot.op == xdip_pkg::OP_MICRO) begin
      slot.decClass = xdip_pkg::CLS_VECTOR;
    end else if (slot.length > xdip_pkg::SHORT_MAX_LEN) begin
      slot.decClass = xdip_pkg::CLS_LONG;
    end else begin
      slot.decClass = xdip_pkg::CLS_SHORT;
    end
    case (slot.op)
      xdip_pkg::OP_CARRY: slot.unit = xdip_pkg::UNIT_INTX;
      xdip_pkg::OP_SHIFT_IMM: slot.unit = xdip_pkg::UNIT_INTX;
      xdip_pkg::OP_FP: slot.unit = xdip_pkg::UNIT_FPU;
      xdip_pkg::OP_COND_JUMP: slot.unit = xdip_pkg::UNIT_BRANCH;
      xdip_pkg::OP_LOAD: slot.unit = xdip_pkg::UNIT_LOAD;
      xdip_pkg::OP_STORE: slot.unit = xdip_pkg::UNIT_STORE;
      default: slot.unit = xdip_pkg::UNIT_INTY;
    endcase
    slot.needsPrefixDelay = slot.valid &&
      (slot.prefixCount > xdip_pkg::PREFIX_FREE);
    slot.accessDelay = slot.valid && slot.misaligned &&
      (slot.op == xdip_pkg::OP_LOAD || slot.op == xdip_pkg::OP_STORE);
  end
endmodule : xdip_classify

// ---- core/xdip_decode_issue.sv ----
`timescale 1ns/1ps
module xdip_decode_issue (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Fetch side, two slots
  input wire logic fetchValid0,
  input wire logic [3:0] fetchLen0,
  input wire logic [1:0] fetchPrefix0,
  input wire xdip_pkg::xdip_op_e fetchOp0,
  input wire logic fetchMisalign0,
  input wire logic fetchValid1,
  input wire logic [3:0] fetchLen1,
  input wire logic [1:0] fetchPrefix1,
  input wire xdip_pkg::xdip_op_e fetchOp1,
  input wire logic fetchMisalign1,
  input wire logic lineSplit,
  input wire logic completeAvail,
  input wire logic regDepend,
  // Branch resolution
  input wire logic mispredict,
  input wire logic [2:0] resolveStage,
  // Decode outputs
  output logic fetchReady,
  output logic issueValid0,
  output logic issueValid1,
  output xdip_pkg::xdip_unit_e issueUnit0,
  output xdip_pkg::xdip_unit_e issueUnit1,
  output xdip_pkg::xdip_class_e issueClass0,
  output xdip_pkg::xdip_class_e issueClass1,
  output logic issueExtraCycle0,
  output logic issueExtraCycle1
);
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_PREFIX = 2'b01,
    ST_FLUSH = 2'b10
  } xdip_state_e;

  xdip_slot_if s0 ();
  xdip_slot_if s1 ();
  xdip_classify u_cls0 (.slot(s0));
  xdip_classify u_cls1 (.slot(s1));

  assign s0.valid = fetchValid0;
  assign s0.length = fetchLen0;
  assign s0.prefixCount = fetchPrefix0;
  assign s0.op = fetchOp0;
  assign s0.misaligned = fetchMisalign0;
  assign s1.valid = fetchValid1;
  assign s1.length = fetchLen1;
  assign s1.prefixCount = fetchPrefix1;
  assign s1.op = fetchOp1;
  assign s1.misaligned = fetchMisalign1;

  xdip_state_e state_reg, state_next;
  logic [2:0] flush_reg, flush_next;
  logic v0_reg, v0_next, v1_reg, v1_next;
  xdip_pkg::xdip_unit_e u0_reg, u0_next, u1_reg, u1_next;
  xdip_pkg::xdip_class_e c0_reg, c0_next, c1_reg, c1_next;
  logic x0_reg, x0_next, x1_reg, x1_next;

  function automatic logic [2:0] clampPenalty(input logic [2:0] stage);
    if (stage < xdip_pkg::MISPRED_MIN) begin
      clampPenalty = xdip_pkg::MISPRED_MIN;
    end else if (stage > xdip_pkg::MISPRED_MAX) begin
      clampPenalty = xdip_pkg::MISPRED_MAX;
    end else begin
      clampPenalty = stage;
    end
  endfunction : clampPenalty

  logic splitStall;
  logic pairOk;
  logic canDecode;
  logic [1:0] unused;

  always_comb begin
    unused = {regDepend, 1'b0};
    splitStall = lineSplit && !completeAvail;
    // Second slot pairs only when both short and not both on X unit
    pairOk = fetchValid1 && s0.decClass == xdip_pkg::CLS_SHORT &&
      s1.decClass == xdip_pkg::CLS_SHORT &&
      !(s0.unit == xdip_pkg::UNIT_INTX && s1.unit == xdip_pkg::UNIT_INTX) &&
      !s1.needsPrefixDelay;
    // Prefix slot still waits out a line split
    canDecode = (state_reg == ST_RUN && !splitStall && !mispredict &&
      !s0.needsPrefixDelay) || (state_reg == ST_PREFIX && !splitStall);
  end

  always_comb begin
    state_next = state_reg;
    flush_next = flush_reg;
    v0_next = 1'b0;
    v1_next = 1'b0;
    u0_next = u0_reg;
    u1_next = u1_reg;
    c0_next = c0_reg;
    c1_next = c1_reg;
    x0_next = 1'b0;
    x1_next = 1'b0;
    case (state_reg)
      ST_RUN: begin
        if (mispredict) begin
          state_next = ST_FLUSH;
          flush_next = clampPenalty(resolveStage) - 3'h1;
        end else if (fetchValid0 && !splitStall &&
            s0.needsPrefixDelay) begin
          state_next = ST_PREFIX;
        end
      end
      ST_PREFIX: begin
        if (mispredict) begin
          state_next = ST_FLUSH;
          flush_next = clampPenalty(resolveStage) - 3'h1;
        end else if (!splitStall) begin
          state_next = ST_RUN;
        end
      end
      ST_FLUSH: begin
        if (flush_reg == 3'h0) begin
          state_next = ST_RUN;
        end else begin
          flush_next = flush_reg - 3'h1;
        end
      end
      default: state_next = ST_RUN;
    endcase
    if (canDecode && !mispredict && fetchValid0) begin
      v0_next = 1'b1;
      u0_next = s0.unit;
      c0_next = s0.decClass;
      x0_next = s0.accessDelay;
      if (pairOk) begin
        v1_next = 1'b1;
        u1_next = s1.unit;
        c1_next = s1.decClass;
        x1_next = s1.accessDelay;
      end
    end
    if (!reset_n) begin
      state_next = ST_RUN;
      flush_next = 3'h0;
      v0_next = 1'b0;
      v1_next = 1'b0;
      u0_next = xdip_pkg::UNIT_INTY;
      u1_next = xdip_pkg::UNIT_INTY;
      c0_next = xdip_pkg::CLS_SHORT;
      c1_next = xdip_pkg::CLS_SHORT;
      x0_next = 1'b0;
      x1_next = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    state_reg <= state_next;
    flush_reg <= flush_next;
    v0_reg <= v0_next;
    v1_reg <= v1_next;
    u0_reg <= u0_next;
    u1_reg <= u1_next;
    c0_reg <= c0_next;
    c1_reg <= c1_next;
    x0_reg <= x0_next;
    x1_reg <= x1_next;
  end

  // Fetch slots consumed only on the cycle they are decoded
  assign fetchReady = reset_n && canDecode && !mispredict;
  assign issueValid0 = v0_reg;
  assign issueValid1 = v1_reg;
  assign issueUnit0 = u0_reg;
  assign issueUnit1 = u1_reg;
  assign issueClass0 = c0_reg;
  assign issueClass1 = c1_reg;
  assign issueExtraCycle0 = x0_reg;
  assign issueExtraCycle1 = x1_reg;
endmodule : xdip_decode_issue

// ---- verif/xdip_monitor.sv ----
`timescale 1ns/1ps
module xdip_monitor (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Fetch side
  input wire logic fetchValid0,
  input wire logic [3:0] fetchLen0,
  input wire logic [1:0] fetchPrefix0,
  input wire xdip_pkg::xdip_op_e fetchOp0,
  input wire logic fetchMisalign0,
  input wire logic lineSplit,
  input wire logic completeAvail,
  input wire logic mispredict,
  input wire logic [2:0] resolveStage,
  // Issue side
  input wire logic fetchReady,
  input wire logic issueValid0,
  input wire logic issueValid1,
  input wire xdip_pkg::xdip_unit_e issueUnit0,
  input wire xdip_pkg::xdip_class_e issueClass0,
  input wire xdip_pkg::xdip_class_e issueClass1,
  input wire logic issueExtraCycle0
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  logic take;
  assign take = fetchValid0 && fetchReady && !mispredict;
  line_stall_a: assert property (lineSplit && !completeAvail |-> !fetchReady)
    else $error("slot taken without a whole instruction");
  flush_min_a: assert property (mispredict |=> !fetchReady)
    else $error("no flush after mispredict");
  flush_max_a: assert property (mispredict && resolveStage >= 3'h4 |=>
    !fetchReady [*4]) else $error("flush shorter than four");
  carry_unit_a: assert property (take && fetchOp0 == xdip_pkg::OP_CARRY
    |=> issueUnit0 == xdip_pkg::UNIT_INTX) else $error("carry unit");
  shift_unit_a: assert property (take && fetchOp0 == xdip_pkg::OP_SHIFT_IMM
    |=> issueUnit0 == xdip_pkg::UNIT_INTX) else $error("shift unit");
  fp_unit_a: assert property (take && fetchOp0 == xdip_pkg::OP_FP
    |=> issueUnit0 == xdip_pkg::UNIT_FPU) else $error("fp unit");
  prefix_free_a: assert property (take && fetchPrefix0 < 2'h2
    |=> issueValid0) else $error("delay without prefixes");
  jump_short_a: assert property (take && fetchLen0 < 4'h8 &&
    fetchOp0 == xdip_pkg::OP_COND_JUMP |=> issueValid0 &&
    issueClass0 == xdip_pkg::CLS_SHORT) else $error("jump class");
  long_class_a: assert property (take && fetchLen0 > 4'h7
    |=> issueClass0 != xdip_pkg::CLS_SHORT) else $error("long short");
  pair_short_a: assert property (issueValid1
    |-> issueClass1 == xdip_pkg::CLS_SHORT) else $error("pair class");
  misalign_a: assert property (take && fetchOp0 == xdip_pkg::OP_LOAD
    |=> issueExtraCycle0 == $past(fetchMisalign0))
    else $error("misalign delay");
endmodule : xdip_monitor
bind xdip_decode_issue xdip_monitor xdip_monitor_i (.*);

// ---- verif/xdip_line_model.sv ----
`timescale 1ns/1ps
module xdip_line_model (
  // Clock and mode
  input wire logic core_clk,
  input wire logic busy,
  // Line status
  output logic lineSplit,
  output logic completeAvail,
  output logic regDepend
);
  initial {lineSplit, completeAvail, regDepend} = 3'h2;
  // Random line crossings and dependencies while busy
  always @(posedge core_clk) begin
    #1 {lineSplit, completeAvail, regDepend} = busy ? 3'($urandom) : 3'h2;
  end
endmodule : xdip_line_model

// ---- verif/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  logic core_clk = 1'b0, reset_n = 1'b0, busy = 1'b0, mispredict = 1'b0;
  logic fetchValid0 = 1'b0, fetchValid1 = 1'b0;
  logic fetchMisalign0 = 1'b0, fetchMisalign1 = 1'b0;
  logic [3:0] fetchLen0 = 4'h1, fetchLen1 = 4'h2;
  logic [1:0] fetchPrefix0 = 2'h0, fetchPrefix1 = 2'h0;
  logic [2:0] resolveStage = 3'h0;
  xdip_pkg::xdip_op_e fetchOp0 = xdip_pkg::OP_ALU;
  xdip_pkg::xdip_op_e fetchOp1 = xdip_pkg::OP_LOAD;
  logic lineSplit, completeAvail, regDepend, fetchReady;
  logic issueValid0, issueValid1, issueExtraCycle0, issueExtraCycle1;
  xdip_pkg::xdip_unit_e issueUnit0, issueUnit1;
  xdip_pkg::xdip_class_e issueClass0, issueClass1;
  logic [6:0] q0[$], q1[$], n0;
  int errors = 0, checked = 0;
  always #10 core_clk = ~core_clk;
  xdip_decode_issue xdip_decode_issue_i (.*);
  xdip_line_model xdip_line_model_i (.*);
  task automatic cmp_bit(string s, logic e, logic g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %b seen %b", s, e, g);
    end
  endtask : cmp_bit
  task automatic cmp_unit(string s, logic [2:0] e, xdip_pkg::xdip_unit_e g);
    checked++;
    if (g !== xdip_pkg::xdip_unit_e'(e)) begin
      errors++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask : cmp_unit
  task automatic cmp_class(string s, logic [1:0] e, xdip_pkg::xdip_class_e g);
    checked++;
    if (g !== xdip_pkg::xdip_class_e'(e)) begin
      errors++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask : cmp_class
  // Note: check flag, unit, class, extra cycle
  function automatic logic [6:0] note_of(logic [2:0] op, logic [3:0] l,
      logic m);
    logic [3:0] u;
    logic [1:0] c;
    u = op == 3'h1 || op == 3'h2 ? 4'h8 : op == 3'h3 ? 4'hA :
      op == 3'h4 ? 4'hB : op == 3'h5 ? 4'hC : op == 3'h6 ? 4'hD : 4'h0;
    c = op == 3'h7 ? 2'h2 : l > xdip_pkg::SHORT_MAX_LEN ? 2'h1 : 2'h0;
    return {u, c, m && (op == 3'h5 || op == 3'h6)};
  endfunction : note_of
  task automatic put(logic [2:0] op, logic [3:0] l, logic [1:0] p, logic m,
      logic pr);
    #1;
    {fetchValid0, fetchLen0, fetchPrefix0, fetchMisalign0} = {1'b1, l, p, m};
    fetchOp0 = xdip_pkg::xdip_op_e'(op);
    fetchValid1 = pr;
    q0.push_back(note_of(op, l, m));
    if (pr) q1.push_back(note_of(3'h5, 4'h2, 1'b0));
    repeat (60) begin
      @(negedge core_clk);
      if (fetchReady === 1'b1) break;
    end
    @(posedge core_clk);
  endtask : put
  always @(negedge core_clk) begin
    if (reset_n && issueValid0 === 1'b1) begin
      n0 = q0.size() > 0 ? q0.pop_front() : 7'h7F;
      if (n0[6]) cmp_unit("unit0", n0[5:3], issueUnit0);
      cmp_class("class0", n0[2:1], issueClass0);
      cmp_bit("extra0", n0[0], issueExtraCycle0);
    end
    if (reset_n && issueValid1 === 1'b1) begin
      n0 = q1.size() > 0 ? q1.pop_front() : 7'h7F;
      cmp_class("class1", n0[2:1], issueClass1);
      if (n0[6]) cmp_unit("unit1", n0[5:3], issueUnit1);
      cmp_bit("extra1", n0[0], issueExtraCycle1);
    end
  end
  task automatic stop_test;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  initial begin
    #400000;
    errors++;
    stop_test();
  end
  initial begin
    void'($urandom(16));
    repeat (10) @(posedge core_clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 8; i++) put(3'(i), 4'h3, 2'h0, 1'b1, 1'b0);
    put(3'h1, 4'h9, 2'h0, 1'b0, 1'b0);
    put(3'h0, 4'h2, 2'h2, 1'b0, 1'b0);
    put(3'h4, 4'h2, 2'h0, 1'b0, 1'b1);
    for (int s = 0; s < 6; s++) begin
      #1 {fetchValid0, fetchValid1, mispredict} = 3'h1;
      resolveStage = 3'(s);
      @(posedge core_clk);
      #1 mispredict = 1'b0;
      @(posedge core_clk);
      put(3'h4, 4'h2, 2'h0, 1'b0, 1'b0);
    end
    busy <= 1'b1;
    repeat (80) put(3'($urandom), 4'($urandom_range(15, 1)), 2'($urandom),
      1'($urandom), 1'b0);
    #1 {fetchValid0, busy} = 2'h0;
    repeat (6) @(posedge core_clk);
    cmp_bit("all issued", 1'b1, q0.size() == 0 && q1.size() == 0);
    stop_test();
  end
endmodule : tb_top
